// *** hdl/rft2_timer_two.sv ***
/*
  Second general-purpose 16-bit down-counting timer of the reader
  frontend, with its byte register file and the timer-one count bytes.
  Assumes one 200 MHz core clock; the 13.56 MHz, 212 kHz and oscillator
  levels arrive from other domains; all other inputs share i_clk.
*/
// Decided for this implementation: the plain strobed port.
// Operation
// - The timer-one low byte register reads bits 7..0 of the live count.
// - With bit 7 set the timer halts once the first 4 rx bits arrived.
// - In either oscillator trimming mode the stop-on-receive bit is ignored.
// - Start mode 00 never starts automatically; 01 starts at tx end.
// - Modes 10 and 11 trim the oscillator, start/stop on rising edges.
// - With bit 3 set the timer reloads and keeps counting at zero, except in start mode 10.
// - With bit 3 clear the timer stops at zero until the next start, except in start mode 10.
// - Every underflow sets the timer-two underflow flag.
// - Tick source 00 is 13.56 MHz and 01 is 212 kHz.
// - Tick source 10 is timer-zero and 11 timer-one underflow.
// - Each start event loads the counter from the 16-bit reload value.
// - Writing a reload byte never disturbs a running count.
// - Reload high and low registers hold the reload bytes, read/write.
// - The timer-one high byte register reads bits 15..8 of the live count.
module rft2_timer_two
  import rft2_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Tick clocks from other domains
  input wire logic i_clk_13m56,
  input wire logic i_clk_212k,
  input wire logic i_low_freq_osc,
  // Same-domain events
  input wire logic i_t0_underflow,
  input wire logic i_t1_underflow,
  input wire logic i_tx_end,
  input wire logic i_rx_nibble,
  input wire logic [CNT_W-1:0] i_timer_one_count,
  // Results
  output logic o_underflow,
  output logic o_running,
  output logic o_irq
);

  logic [DATA_W-1:0] timer_two_control;
  logic [DATA_W-1:0] timer_two_reload_high;
  logic [DATA_W-1:0] timer_two_reload_low;
  logic [DATA_W-1:0] irq_mask;
  logic timer_two_underflow_flag;
  logic [CNT_W-1:0] count;
  logic running;
  logic [2:0] sync_13m56;
  logic [2:0] sync_212k;
  logic [2:0] sync_lfo;

  logic stop_on_rx_nibble;
  logic reload_on_zero;
  rft2_start_t auto_start_select;
  rft2_tick_t tick_source_select;
  logic [CNT_W-1:0] reload_value_word;
  logic lfo_mode;
  logic lfo_rise;
  logic tick;
  logic sw_start;
  logic sw_stop;
  logic start_evt;
  logic stop_evt;
  logic at_zero_tick;
  logic uf_now;
  logic wr_status;
  logic [CNT_W-1:0] next_count;
  logic next_running;

  assign stop_on_rx_nibble = timer_two_control[CTL_STOP_RX_BIT];
  assign reload_on_zero = timer_two_control[CTL_RELOAD_BIT];
  assign auto_start_select =
    rft2_start_t'(timer_two_control[CTL_START_HI:CTL_START_LO]);
  assign tick_source_select =
    rft2_tick_t'(timer_two_control[CTL_TICK_HI:CTL_TICK_LO]);
  assign reload_value_word = {timer_two_reload_high, timer_two_reload_low};
  assign lfo_mode = (auto_start_select == START_LFO_NO_UF) ||
                    (auto_start_select == START_LFO_UF);

  // Two-flop synchronisers plus one history flop for edge detection
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      sync_13m56 <= 3'h0;
      sync_212k <= 3'h0;
      sync_lfo <= 3'h0;
    end
    else if (i_clk_en)
    begin
      sync_13m56 <= {sync_13m56[1:0], i_clk_13m56};
      sync_212k <= {sync_212k[1:0], i_clk_212k};
      sync_lfo <= {sync_lfo[1:0], i_low_freq_osc};
    end
  end

  assign lfo_rise = sync_lfo[1] & ~sync_lfo[2];

  // Tick selection; cascade sources are already core-clock pulses
  always_comb
  begin
    case (tick_source_select)
      TICK_13M56: tick = sync_13m56[1] & ~sync_13m56[2];
      TICK_212K: tick = sync_212k[1] & ~sync_212k[2];
      TICK_T0_UF: tick = i_t0_underflow;
      TICK_T1_UF: tick = i_t1_underflow;
      default: tick = 1'b0;
    endcase
  end

  assign sw_start = i_wr && (i_addr == OFS_COMMAND) && i_wdata[CMD_START_BIT];
  assign sw_stop = i_wr && (i_addr == OFS_COMMAND) && i_wdata[CMD_STOP_BIT];

  // Oscillator edge starts an idle timer and stops a running one
  assign start_evt = sw_start ||
    ((auto_start_select == START_TX_END) && i_tx_end) ||
    (lfo_mode && lfo_rise && !running);
  assign stop_evt = sw_stop ||
    (lfo_mode && lfo_rise && running) ||
    (stop_on_rx_nibble && !lfo_mode && i_rx_nibble && running);

  assign at_zero_tick = running && tick && (count == CNT_RESET);
  // No underflow in trimming without underflow: the count saturates
  assign uf_now = at_zero_tick && !start_evt && !stop_evt &&
                  (auto_start_select != START_LFO_NO_UF);

  always_comb
  begin
    next_count = count;
    next_running = running;
    if (start_evt)
    begin
      next_count = reload_value_word;
      next_running = 1'b1;
    end
    else if (stop_evt)
    begin
      next_running = 1'b0;
    end
    else if (running && tick)
    begin
      if (count != CNT_RESET)
      begin
        next_count = count - CNT_ONE;
      end
      else if (auto_start_select == START_LFO_NO_UF)
      begin
        next_count = count;
      end
      else if (reload_on_zero)
      begin
        next_count = reload_value_word;
      end
      else
      begin
        next_running = 1'b0;
      end
    end
  end

  // Reload bytes are sampled only at start or reload, never mid-count
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      count <= CNT_RESET;
      running <= 1'b0;
    end
    else if (i_clk_en)
    begin
      count <= next_count;
      running <= next_running;
    end
  end

  // Software registers
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      timer_two_control <= CTL_RESET;
      timer_two_reload_high <= RELOAD_RESET;
      timer_two_reload_low <= RELOAD_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end
    else if (i_clk_en && i_wr)
    begin
      case (i_addr)
        OFS_T2_CONTROL: timer_two_control <= i_wdata & CTL_WMASK;
        OFS_T2_RELOAD_HIGH: timer_two_reload_high <= i_wdata;
        OFS_T2_RELOAD_LOW: timer_two_reload_low <= i_wdata;
        OFS_IRQ_MASK: irq_mask <= i_wdata & IRQ_IMPL_MASK;
        default: ;
      endcase
    end
  end

  // Sticky flag: a new underflow wins over a write-one clear
  assign wr_status = i_wr && (i_addr == OFS_IRQ_STATUS) &&
                     i_wdata[IRQ_UNDERFLOW_BIT];

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      timer_two_underflow_flag <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (uf_now)
      begin
        timer_two_underflow_flag <= 1'b1;
      end
      else if (wr_status)
      begin
        timer_two_underflow_flag <= 1'b0;
      end
    end
  end

  // Registered outputs; underflow pulse also feeds cascaded timers
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_underflow <= 1'b0;
      o_running <= 1'b0;
      o_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_underflow <= uf_now;
      o_running <= next_running;
      o_irq <= (uf_now || (timer_two_underflow_flag && !wr_status)) &&
               irq_mask[IRQ_UNDERFLOW_BIT];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero.
  // Live count bytes are not coherent during reception.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= READ_ZERO;
    end
    else if (i_clk_en)
    begin
      o_rdata <= READ_ZERO;
      if (i_rd)
      begin
        case (i_addr)
          OFS_T1_COUNT_HIGH:
            o_rdata <= i_timer_one_count[CNT_W-1:DATA_W];
          OFS_T1_COUNT_LOW: o_rdata <= i_timer_one_count[DATA_W-1:0];
          OFS_T2_CONTROL: o_rdata <= timer_two_control;
          OFS_T2_RELOAD_HIGH: o_rdata <= timer_two_reload_high;
          OFS_T2_RELOAD_LOW: o_rdata <= timer_two_reload_low;
          OFS_IRQ_STATUS:
            o_rdata <= {7'h00, timer_two_underflow_flag};
          OFS_IRQ_MASK: o_rdata <= irq_mask;
          OFS_RUN_STATUS: o_rdata <= {7'h00, running};
          default: o_rdata <= READ_ZERO;
        endcase
      end
    end
  end

  chk_rx_halts: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && running && stop_on_rx_nibble && !lfo_mode &&
    i_rx_nibble && !start_evt |=> !running)
    else $error("timer kept running after rx nibble");

  chk_lfo_ignores_rx: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && running && lfo_mode && i_rx_nibble && !lfo_rise &&
    !sw_stop && !at_zero_tick |=> running)
    else $error("rx nibble stopped timer in trimming mode");

  chk_tx_start_load: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && (auto_start_select == START_TX_END) && i_tx_end
    |=> running && (count == $past(reload_value_word)))
    else $error("tx end did not start timer with reload value");

  chk_no_auto_start: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !running && (auto_start_select == START_NONE) && !sw_start
    |=> !running)
    else $error("timer started without a start event");

  chk_lfo_edge_start: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && lfo_mode && lfo_rise && !running |=> running)
    else $error("oscillator edge did not start timer");

  chk_zero_reload: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && uf_now && reload_on_zero
    |=> running && (count == $past(reload_value_word)))
    else $error("timer did not reload at zero");

  chk_zero_stop: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && uf_now && !reload_on_zero
    |=> !running ##1 (!running || $past(start_evt)))
    else $error("timer did not stop at zero");

  chk_flag_on_uf: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && uf_now |=> timer_two_underflow_flag && o_underflow)
    else $error("underflow did not set the flag");

  chk_tick_decrement: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && running && tick && (count != CNT_RESET) &&
    !start_evt && !stop_evt |=> count == $past(count) - CNT_ONE)
    else $error("count did not drop by one on tick");

  chk_t1_low_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && i_rd && (i_addr == OFS_T1_COUNT_LOW)
    |=> o_rdata == $past(i_timer_one_count[DATA_W-1:0]))
    else $error("timer-one low byte read mismatch");

  chk_reserved_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && i_rd && (i_addr == OFS_T2_CONTROL)
    |=> !o_rdata[CTL_RSVD_A_BIT] && !o_rdata[CTL_RSVD_B_BIT])
    else $error("reserved control bits read non-zero");

endmodule

// *** hdl/rft2_pkg.sv ***
/*
  Constants for the second reader-frontend down-counting timer:
  register offsets, field positions, reset values and mode codes.
  Assumes an 8-bit register address space and byte-wide registers.
*/
package rft2_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_T1_COUNT_HIGH = 8'h17;
  localparam logic [ADDR_W-1:0] OFS_T1_COUNT_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_T2_CONTROL = 8'h19;
  localparam logic [ADDR_W-1:0] OFS_T2_RELOAD_HIGH = 8'h1a;
  localparam logic [ADDR_W-1:0] OFS_T2_RELOAD_LOW = 8'h1b;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h31;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h32;
  localparam logic [ADDR_W-1:0] OFS_RUN_STATUS = 8'h33;

  // Control field positions
  localparam int CTL_STOP_RX_BIT = 7;
  localparam int CTL_START_HI = 5;
  localparam int CTL_START_LO = 4;
  localparam int CTL_RELOAD_BIT = 3;
  localparam int CTL_TICK_HI = 1;
  localparam int CTL_TICK_LO = 0;
  localparam int CTL_RSVD_A_BIT = 6;
  localparam int CTL_RSVD_B_BIT = 2;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'hbb;

  // Command, status and interrupt bits
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int RUN_BIT = 0;
  localparam logic [DATA_W-1:0] IRQ_IMPL_MASK = 8'h01;

  // Reset values
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RELOAD_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    START_NONE = 2'b00,
    START_TX_END = 2'b01,
    START_LFO_NO_UF = 2'b10,
    START_LFO_UF = 2'b11
  } rft2_start_t;

  typedef enum logic [1:0] {
    TICK_13M56 = 2'b00,
    TICK_212K = 2'b01,
    TICK_T0_UF = 2'b10,
    TICK_T1_UF = 2'b11
  } rft2_tick_t;

endpackage

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the second reader-frontend down-counter.
  Assumes the design package and timer module are compiled first,
  one 200 MHz clock, and a bench that drives every port itself.
*/
module tb_top
  import rft2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic i_clk_13m56 = 1'b0;
  logic i_clk_212k = 1'b0;
  logic i_low_freq_osc = 1'b0;
  logic i_t0_underflow = 1'b0;
  logic i_t1_underflow = 1'b0;
  logic i_tx_end = 1'b0;
  logic i_rx_nibble = 1'b0;
  logic [CNT_W-1:0] i_timer_one_count = 16'h0000;
  logic o_underflow;
  logic o_running;
  logic o_irq;
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'hd1e8;
  logic [7:0] exp_q[$];
  logic uf_q[$];
  logic rd_d = 1'b0;
  logic [15:0] v;
  logic [7:0] n;

  rft2_timer_two u_rft2_timer_two (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_clk_13m56(i_clk_13m56),
    .i_clk_212k(i_clk_212k), .i_low_freq_osc(i_low_freq_osc),
    .i_t0_underflow(i_t0_underflow), .i_t1_underflow(i_t1_underflow),
    .i_tx_end(i_tx_end), .i_rx_nibble(i_rx_nibble),
    .i_timer_one_count(i_timer_one_count), .o_underflow(o_underflow),
    .o_running(o_running), .o_irq(o_irq)
  );

  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t read exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_bit(input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t flag exp %b got %b", $time, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask

  // Pin clocks held 4 cycles each level so the synchroniser sees them
  task automatic tick(input logic [1:0] s);
    @(posedge i_clk);
    case (s)
      2'b00: i_clk_13m56 <= 1'b1;
      2'b01: i_clk_212k <= 1'b1;
      2'b10: i_t0_underflow <= 1'b1;
      default: i_t1_underflow <= 1'b1;
    endcase
    @(posedge i_clk);
    i_t0_underflow <= 1'b0;
    i_t1_underflow <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_clk_13m56 <= 1'b0;
    i_clk_212k <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic evt(input logic rx);
    @(posedge i_clk);
    if (rx)
      i_rx_nibble <= 1'b1;
    else
      i_tx_end <= 1'b1;
    @(posedge i_clk);
    i_rx_nibble <= 1'b0;
    i_tx_end <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic osc();
    @(posedge i_clk);
    i_low_freq_osc <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_low_freq_osc <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() + uf_q.size() != 0 && k < 200)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 200)
    begin
      err_total++;
      $display("BAD %0t result missing", $time);
      test_done();
    end
  endtask

  // Empty queue yields an x note, so a stray result always mismatches
  always @(posedge i_clk)
  begin
    rd_d <= i_rd;
    if (rd_d)
      chk_byte(exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx, o_rdata);
    if (o_underflow === 1'b1)
      chk_bit(uf_q.size() != 0 ? uf_q.pop_front() : 1'bx, o_running);
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    $display("BAD %0t run hung", $time);
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(OFS_T2_CONTROL, CTL_RESET);
    rd(OFS_T2_RELOAD_HIGH, RELOAD_RESET);
    bus(8'h40, 8'hff, 1'b1);
    rd(8'h40, READ_ZERO);
    bus(OFS_T2_CONTROL, 8'hff, 1'b1);
    rd(OFS_T2_CONTROL, CTL_WMASK);
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($random(seed));
      i_timer_one_count <= v;
      bus(OFS_T2_RELOAD_HIGH, v[15:8], 1'b1);
      bus(OFS_T2_RELOAD_LOW, v[7:0], 1'b1);
      rd(OFS_T2_RELOAD_HIGH, v[15:8]);
      rd(OFS_T2_RELOAD_LOW, v[7:0]);
      rd(OFS_T1_COUNT_LOW, v[7:0]);
      rd(OFS_T1_COUNT_HIGH, v[15:8]);
    end
    for (int s = 0; s < 4; s++)
    begin
      n = 8'($random(seed)) & 8'h03;
      bus(OFS_IRQ_MASK, {7'h00, 1'(s)}, 1'b1);
      bus(OFS_T2_CONTROL, {6'h00, 2'(s)}, 1'b1);
      bus(OFS_T2_RELOAD_HIGH, 8'h00, 1'b1);
      bus(OFS_T2_RELOAD_LOW, n, 1'b1);
      bus(OFS_COMMAND, 8'h01, 1'b1);
      repeat (n) tick(2'(s));
      uf_q.push_back(1'b0);
      tick(2'(s));
      drain();
      repeat (2) @(posedge i_clk);
      chk_bit(1'(s), o_irq);
      rd(OFS_IRQ_STATUS, 8'h01);
      bus(OFS_IRQ_STATUS, 8'h01, 1'b1);
      rd(OFS_IRQ_STATUS, 8'h00);
      chk_bit(1'b0, o_irq);
    end
    bus(OFS_T2_CONTROL, 8'h02, 1'b1);
    bus(OFS_T2_RELOAD_LOW, 8'h01, 1'b1);
    evt(1'b0);
    chk_bit(1'b0, o_running);
    bus(OFS_T2_CONTROL, 8'h12, 1'b1);
    evt(1'b0);
    chk_bit(1'b1, o_running);
    bus(OFS_T2_RELOAD_LOW, 8'h05, 1'b1);
    tick(2'b10);
    uf_q.push_back(1'b0);
    tick(2'b10);
    drain();
    bus(OFS_T2_CONTROL, 8'h0b, 1'b1);
    bus(OFS_T2_RELOAD_LOW, 8'h01, 1'b1);
    bus(OFS_COMMAND, 8'h01, 1'b1);
    repeat (2)
    begin
      tick(2'b11);
      uf_q.push_back(1'b1);
      tick(2'b11);
      drain();
    end
    bus(OFS_COMMAND, 8'h02, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      bus(OFS_T2_CONTROL, k == 1 ? 8'h82 : 8'h02, 1'b1);
      bus(OFS_COMMAND, 8'h01, 1'b1);
      evt(1'b1);
      chk_bit(1'(k == 0), o_running);
      bus(OFS_COMMAND, 8'h02, 1'b1);
    end
    bus(OFS_T2_CONTROL, 8'hb2, 1'b1);
    osc();
    chk_bit(1'b1, o_running);
    evt(1'b1);
    chk_bit(1'b1, o_running);
    osc();
    chk_bit(1'b0, o_running);
    // A tick while the enable is low must be lost
    bus(OFS_T2_CONTROL, 8'h02, 1'b1);
    bus(OFS_COMMAND, 8'h01, 1'b1);
    i_clk_en <= 1'b0;
    tick(2'b10);
    i_clk_en <= 1'b1;
    tick(2'b10);
    uf_q.push_back(1'b0);
    tick(2'b10);
    drain();
    // Trimming without underflow: count saturates at zero
    bus(OFS_T2_CONTROL, 8'h22, 1'b1);
    bus(OFS_T2_RELOAD_LOW, 8'h00, 1'b1);
    osc();
    tick(2'b10);
    chk_bit(1'b1, o_running);
    osc();
    chk_bit(1'b0, o_running);
    // Reset in mid-run while the timer runs, its count saturated at zero
    bus(OFS_COMMAND, 8'h01, 1'b1);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(OFS_T2_CONTROL, CTL_RESET);
    rd(OFS_T2_RELOAD_LOW, RELOAD_RESET);
    drain();
    test_done();
  end
endmodule
